// file: sdbc_pkg.sv
// Purpose: Shared constants, types and decode functions for the SDRAM core.
// Assumes: 100 MHz clock, column latency of three clocks.
// Notes:   Register offsets are byte addresses on the AHB-Lite bus.

package sdbc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          CLK_NS      = 10;
    localparam int          CAS_LAT     = 3;
    localparam int          RD_MASK_LAT = 2;
    localparam int          TRP_NS      = 20;
    localparam logic [7:0]  TRP_CYC     = 8'((TRP_NS + CLK_NS - 1) / CLK_NS);

    // ************************************************************
    // Address fields
    // ************************************************************
    localparam int          BANK_BIT    = 11;
    localparam int          AP_BIT      = 10;
    localparam int          ROW_MSB     = 10;
    localparam int          COL_MSB     = 7;

    // ************************************************************
    // Registers
    // ************************************************************
    localparam logic [31:0] CFG_OFS     = 32'h0000_0000;
    localparam logic [31:0] STAT_OFS    = 32'h0000_0004;
    localparam logic [2:0]  CFG_RST     = 3'h2;
    localparam logic [2:0]  BL_FULL     = 3'h7;
    localparam int          ST_ACT_LSB  = 0;
    localparam int          ST_PRE_LSB  = 2;
    localparam int          ST_RD_BIT   = 4;
    localparam int          ST_WR_BIT   = 5;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [11:0] addr;
    } sdbc_cmd_s;

    typedef enum logic [2:0] {
        OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_STOP
    } sdbc_op_e;

    typedef enum logic [1:0] {
        BK_IDLE, BK_ACTIVE, BK_PRECH
    } sdbc_bank_e;

    // ************************************************************
    // Functions
    // ************************************************************
    // Decodes the command pins sampled at a rising edge.
    function automatic sdbc_op_e sdbc_op_decode(input sdbc_cmd_s c);
        sdbc_op_e op;
        op = OP_NOP;
        if (!c.cs_n)
        begin
            case ({c.ras_n, c.cas_n, c.we_n})
                3'h3:    op = OP_ACT;
                3'h5:    op = OP_RD;
                3'h4:    op = OP_WR;
                3'h2:    op = OP_PRE;
                3'h6:    op = OP_STOP;
                default: op = OP_NOP;
            endcase
        end
        return op;
    endfunction : sdbc_op_decode

    // Returns burst length minus one, which is also the column wrap mask.
    function automatic logic [7:0] sdbc_wrap_mask(input logic [2:0] bl);
        logic [7:0] m;
        case (bl)
            3'h0:    m = 8'h00;
            3'h1:    m = 8'h01;
            3'h2:    m = 8'h03;
            3'h3:    m = 8'h07;
            default: m = 8'hff;
        endcase
        return m;
    endfunction : sdbc_wrap_mask

    // Advances a column sequentially, wrapping inside the burst.
    function automatic logic [7:0] sdbc_col_step(input logic [7:0] col,
                                                 input logic [7:0] m);
        logic [7:0] inc;
        inc = col + 8'h01;
        return (col & ~m) | (inc & m);
    endfunction : sdbc_col_step

endpackage : sdbc_pkg

// file: sdbc_mem.sv
// Purpose: Storage array for both banks with byte write enables.
// Assumes: One access per cycle, read data one cycle after the address.
// Notes:   Address is bank, row, column from the top bit down.

`timescale 1ns/1ps

module sdbc_mem (
    // Clock
    input  wire logic        clk,
    // Access
    input  wire logic [19:0] addr,
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_be,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] rd_data
);

    logic [15:0] mem [1048576];

    // ************************************************************
    // Array access
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (wr_en && wr_be[0])
            mem[addr][7:0] <= wr_data[7:0];
        if (wr_en && wr_be[1])
            mem[addr][15:8] <= wr_data[15:8];
        rd_data <= mem[addr];
    end

endmodule : sdbc_mem

// file: sdbc_core.sv
// Purpose: Command-level core of a two-bank synchronous DRAM.
// Assumes: Commands sampled on clk from a controller on the same clock.
// Notes:   Burst length is set over AHB-Lite; sequential bursts only.
//
// Summary of operation
// R1 - Activate takes row from bits 0-10, bank from bit 11.
// R2 - Read and write take column from bits 0-7, bank from bit 11.
// R3 - Read with bit 10 high bursts, then precharges the bank to idle.
// R4 - Read outputs start column after latency, then successive columns.
// R5 - Outputs drive from latency minus one, release after last word.
// R6 - Read byte masks act two clocks after the mask input.
// R7 - Controller activates the bank before any read or write.
// R8 - Write takes first word with the command, then one per clock.
// R9 - Controller waits write recovery before precharge; stops full pages.
// R10 - Write byte mask blocks storage in the same clock.
// R11 - Read auto-precharge starts two clocks before the last word out.
// R12 - Controller waits precharge time before reactivating the bank.
// R13 - No auto-precharge when burst length is full page.
// R14 - Write auto-precharge starts one clock after the last word.
// R15 - A new read replaces the running read burst after latency.
// R16 - A new write replaces the running write burst at once.
// R17 - A read interrupts a write; read data after latency.
// R18 - Controller masks pending read data when a write interrupts.
// R19 - Bank goes idle the precharge time after precharge.
// R20 - Precharge with bit 10 high closes both banks, else bit 11 bank.
// R21 - Full-page bursts are 256 columns, wrapping in the row.
// R22 - Upper mask governs bits 8-15, lower mask bits 0-7.
// R23 - Burst stop releases read outputs after the column latency.
// R24 - Column latency is three clocks and fixes every derived delay.

`timescale 1ns/1ps

module sdbc_core (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Command pins
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [11:0] addr,
    input  wire logic        upper_byte_mask,
    input  wire logic        lower_byte_mask,
    // Data pins
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic      [1:0]  dq_oe_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp
);

    localparam int TRP_A = int'(sdbc_pkg::TRP_CYC);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'h1};
    end

    assign rst_n = rst_sync[1];

    // ************************************************************
    // Command decode
    // ************************************************************
    sdbc_pkg::sdbc_cmd_s  cmd;
    sdbc_pkg::sdbc_op_e   op;
    sdbc_pkg::sdbc_bank_e bk_st [2];
    sdbc_pkg::sdbc_bank_e next_bk_st [2];
    logic [10:0]          bk_row [2];
    logic [10:0]          next_bk_row [2];
    logic [7:0]           bk_cnt [2];
    logic [7:0]           next_bk_cnt [2];
    logic [2:0]           cfg_bl;
    logic [7:0]           bl_mask;
    logic                 full;
    logic                 cmd_bank;
    logic                 cmd_ok;
    logic                 pre_hit;
    logic                 bst_act, bst_rd, bst_bank, bst_ap;
    logic [7:0]           bst_col, bst_left;
    logic                 next_bst_act, next_bst_rd, next_bst_bank, next_bst_ap;
    logic [7:0]           next_bst_col, next_bst_left;
    logic                 iss, iss_rd, iss_bank, iss_ap, iss_last, ap_fire;
    logic [7:0]           iss_col;

    assign cmd      = {cs_n, ras_n, cas_n, we_n, addr};
    assign op       = sdbc_pkg::sdbc_op_decode(cmd);
    assign cmd_bank = addr[sdbc_pkg::BANK_BIT];                                   // [R1] [R2]
    assign bl_mask  = sdbc_pkg::sdbc_wrap_mask(cfg_bl);                           // [R21]
    assign full     = cfg_bl == sdbc_pkg::BL_FULL;

    // A column command counts only against an active bank.
    assign cmd_ok   = (op == sdbc_pkg::OP_RD || op == sdbc_pkg::OP_WR)
                      && bk_st[cmd_bank] == sdbc_pkg::BK_ACTIVE;                  // [R7]
    assign pre_hit  = op == sdbc_pkg::OP_PRE
                      && (addr[sdbc_pkg::AP_BIT] || cmd_bank == bst_bank);

    // ************************************************************
    // Burst engine
    // ************************************************************
    // A new column command overrides any running burst.
    assign iss      = cmd_ok || (bst_act && op != sdbc_pkg::OP_STOP && !pre_hit); // [R15] [R16] [R17] [R23]
    assign iss_rd   = cmd_ok ? op == sdbc_pkg::OP_RD : bst_rd;
    assign iss_bank = cmd_ok ? cmd_bank : bst_bank;
    assign iss_col  = cmd_ok ? addr[sdbc_pkg::COL_MSB:0] : bst_col;               // [R2] [R4]
    assign iss_ap   = cmd_ok ? addr[sdbc_pkg::AP_BIT] : bst_ap;                   // [R3]
    assign iss_last = !full && (cmd_ok ? bl_mask == 8'h00 : bst_left == 8'h00);   // [R13]
    assign ap_fire  = iss && iss_last && iss_ap;                                  // [R11] [R14]

    always_comb
    begin
        next_bst_act  = bst_act;
        next_bst_rd   = bst_rd;
        next_bst_bank = bst_bank;
        next_bst_ap   = bst_ap;
        next_bst_col  = bst_col;
        next_bst_left = bst_left;
        if (cmd_ok)
        begin
            next_bst_act  = bl_mask != 8'h00;
            next_bst_rd   = op == sdbc_pkg::OP_RD;
            next_bst_bank = cmd_bank;
            next_bst_ap   = addr[sdbc_pkg::AP_BIT];
            next_bst_col  = sdbc_pkg::sdbc_col_step(addr[sdbc_pkg::COL_MSB:0], bl_mask);
            next_bst_left = bl_mask - 8'h01;
        end
        else if (iss)
        begin
            next_bst_act  = !iss_last;                                            // [R8] [R21]
            next_bst_col  = sdbc_pkg::sdbc_col_step(bst_col, bl_mask);
            next_bst_left = bst_left - 8'h01;
        end
        else
        begin
            next_bst_act  = 1'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bst_act  <= 1'h0;
            bst_rd   <= 1'h0;
            bst_bank <= 1'h0;
            bst_ap   <= 1'h0;
            bst_col  <= 8'h00;
            bst_left <= 8'h00;
        end
        else
        begin
            bst_act  <= next_bst_act;
            bst_rd   <= next_bst_rd;
            bst_bank <= next_bst_bank;
            bst_ap   <= next_bst_ap;
            bst_col  <= next_bst_col;
            bst_left <= next_bst_left;
        end
    end

    // ************************************************************
    // Bank state
    // ************************************************************
    always_comb
    begin
        next_bk_st  = bk_st;
        next_bk_row = bk_row;
        next_bk_cnt = bk_cnt;
        for (int b = 0; b < 2; b++)
        begin
            if (bk_st[b] == sdbc_pkg::BK_PRECH)
            begin
                next_bk_cnt[b] = bk_cnt[b] - 8'h01;
                if (bk_cnt[b] == 8'h01)
                    next_bk_st[b] = sdbc_pkg::BK_IDLE;                            // [R19]
            end
            if (op == sdbc_pkg::OP_ACT && cmd_bank == b[0]
                && bk_st[b] == sdbc_pkg::BK_IDLE)
            begin
                next_bk_st[b]  = sdbc_pkg::BK_ACTIVE;                             // [R1]
                next_bk_row[b] = addr[sdbc_pkg::ROW_MSB:0];
            end
            if ((op == sdbc_pkg::OP_PRE && bk_st[b] == sdbc_pkg::BK_ACTIVE
                 && (addr[sdbc_pkg::AP_BIT] || cmd_bank == b[0]))                 // [R20]
                || (ap_fire && iss_bank == b[0]))                                 // [R3] [R11] [R14]
            begin
                next_bk_st[b]  = sdbc_pkg::BK_PRECH;
                next_bk_cnt[b] = sdbc_pkg::TRP_CYC;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bk_st  <= '{sdbc_pkg::BK_IDLE, sdbc_pkg::BK_IDLE};
            bk_row <= '{11'h000, 11'h000};
            bk_cnt <= '{8'h00, 8'h00};
        end
        else
        begin
            bk_st  <= next_bk_st;
            bk_row <= next_bk_row;
            bk_cnt <= next_bk_cnt;
        end
    end

    // ************************************************************
    // Storage and data path
    // ************************************************************
    logic [19:0] mem_addr;
    logic        wr_en;
    logic [1:0]  wr_be;
    logic [15:0] mem_q;
    logic [2:0]  rd_v, next_rd_v;
    logic [15:0] rd_d2, next_rd_d2, next_dq_out;
    logic [1:0]  mq1, mq2, next_mq1, next_mq2;
    logic        drv;

    assign mem_addr = {iss_bank, bk_row[iss_bank], iss_col};
    assign wr_en    = iss && !iss_rd;                                             // [R8]
    assign wr_be    = ~{upper_byte_mask, lower_byte_mask};                        // [R10] [R22]

    sdbc_mem u_mem (
        .clk     (clk),
        .addr    (mem_addr),
        .wr_en   (wr_en),
        .wr_be   (wr_be),
        .wr_data (dq_in),
        .rd_data (mem_q)
    );

    // Array read adds one stage; two more make the three-clock latency.
    always_comb
    begin
        next_rd_v   = {rd_v[1:0], iss && iss_rd};                                 // [R24]
        next_rd_d2  = mem_q;
        next_dq_out = rd_d2;                                                      // [R4]
        next_mq1    = {upper_byte_mask, lower_byte_mask};
        next_mq2    = mq1;                                                        // [R6]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_v   <= 3'h0;
            rd_d2  <= 16'h0000;
            dq_out <= 16'h0000;
            mq1    <= 2'h0;
            mq2    <= 2'h0;
        end
        else
        begin
            rd_v   <= next_rd_v;
            rd_d2  <= next_rd_d2;
            dq_out <= next_dq_out;
            mq1    <= next_mq1;
            mq2    <= next_mq2;
        end
    end

    // Drive from one clock before each word until the last word ends.
    assign drv     = rd_v[1] || rd_v[2];                                          // [R5] [R23]
    assign dq_oe_n = ~({2{drv}} & ~mq2);                                          // [R6] [R22]

    // ************************************************************
    // AHB-Lite registers
    // ************************************************************
    logic        ap_wr, next_ap_wr;
    logic [31:0] ap_addr, next_ap_addr, next_hrdata, stat;
    logic [2:0]  next_cfg_bl;

    always_comb
    begin
        stat = 32'h0000_0000;
        for (int b = 0; b < 2; b++)
        begin
            stat[sdbc_pkg::ST_ACT_LSB + b] = bk_st[b] == sdbc_pkg::BK_ACTIVE;
            stat[sdbc_pkg::ST_PRE_LSB + b] = bk_st[b] == sdbc_pkg::BK_PRECH;
        end
        stat[sdbc_pkg::ST_RD_BIT] = bst_act && bst_rd;
        stat[sdbc_pkg::ST_WR_BIT] = bst_act && !bst_rd;
        next_ap_wr   = hsel && htrans[1] && hwrite && hready;
        next_ap_addr = haddr;
        next_hrdata  = hrdata;
        if (hsel && htrans[1] && !hwrite && hready)
        begin
            if (haddr == sdbc_pkg::CFG_OFS)
                next_hrdata = {29'h0000_0000, cfg_bl};
            else if (haddr == sdbc_pkg::STAT_OFS)
                next_hrdata = stat;
            else
                next_hrdata = 32'h0000_0000;
        end
        next_cfg_bl = cfg_bl;
        if (ap_wr && ap_addr == sdbc_pkg::CFG_OFS)
            next_cfg_bl = hwdata[2:0];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ap_wr   <= 1'h0;
            ap_addr <= 32'h0000_0000;
            hrdata  <= 32'h0000_0000;
            cfg_bl  <= sdbc_pkg::CFG_RST;
        end
        else
        begin
            ap_wr   <= next_ap_wr;
            ap_addr <= next_ap_addr;
            hrdata  <= next_hrdata;
            cfg_bl  <= next_cfg_bl;
        end
    end

    assign hreadyout = 1'h1;
    assign hresp     = 1'h0;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_rd_start;
        cmd_ok && op == sdbc_pkg::OP_RD;
    endsequence

    sequence s_drive_two;
        drv ##1 drv;
    endsequence

    a_act_row_take: assert property ((op == sdbc_pkg::OP_ACT && !addr[11]    // [R1]
        && bk_st[0] == sdbc_pkg::BK_IDLE) |=> (bk_st[0] == sdbc_pkg::BK_ACTIVE
        && bk_row[0] == $past(addr[10:0])))
        else $error("Activate did not latch row into bank 0.");

    a_col_addr_take: assert property (cmd_ok |-> (mem_addr[7:0] == addr[7:0]
        && mem_addr[19] == addr[11]))                                            // [R2]
        else $error("Column command used a wrong column or bank.");

    a_rd_low_z: assert property (s_rd_start |-> ##2 s_drive_two)                 // [R5]
        else $error("Read outputs not driven from latency minus one.");

    a_rd_data_lat: assert property (s_rd_start |-> ##3 dq_out == $past(mem_q, 2)) // [R4]
        else $error("Read word not output after three clocks.");

    a_rd_mask_lat: assert property (lower_byte_mask |-> ##2 dq_oe_n[0])          // [R6]
        else $error("Lower byte not released two clocks after mask.");

    a_wr_zero_lat: assert property ((iss && !iss_rd && lower_byte_mask)   // [R8] [R10]
        |-> (wr_en && !wr_be[0] && wr_be[1] == !upper_byte_mask))
        else $error("Write not taken with its command or mask ignored.");

    a_pre_all_bank: assert property ((op == sdbc_pkg::OP_PRE && addr[10]     // [R20]
        && bk_st[0] == sdbc_pkg::BK_ACTIVE && bk_st[1] == sdbc_pkg::BK_ACTIVE)
        |=> (bk_st[0] == sdbc_pkg::BK_PRECH && bk_st[1] == sdbc_pkg::BK_PRECH))
        else $error("Precharge all did not close both banks.");

    a_prech_to_idle: assert property ((bk_st[0] == sdbc_pkg::BK_PRECH       // [R19]
        && bk_cnt[0] == sdbc_pkg::TRP_CYC) |-> ##TRP_A bk_st[0] == sdbc_pkg::BK_IDLE)
        else $error("Bank 0 not idle after precharge time.");

    a_ap_start: assert property ((ap_fire && !iss_bank)                      // [R11]
        |=> bk_st[0] == sdbc_pkg::BK_PRECH)
        else $error("Auto-precharge did not start after last word.");

    a_ap_full_off: assert property (full |-> !ap_fire)                           // [R13]
        else $error("Auto-precharge fired in full-page mode.");

endmodule : sdbc_core

// file: sdbc_ctl_model.sv
// Purpose: Controller model that drives commands, byte masks and write data.
// Assumes: The bench calls one task per clock and orders the commands.
// Notes:   Released data lines toggle so a stale value never passes.

`timescale 1ns/1ps

module sdbc_ctl_model (
    // Clock
    input  wire logic        clk,
    // Command pins
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic      [11:0] addr,
    output logic             upper_byte_mask,
    output logic             lower_byte_mask,
    // Data pins
    output logic      [15:0] dq_in
);
    // ************************************************************
    // Command driver
    // ************************************************************
    initial
    begin
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        addr = 12'h000;
        dq_in = 16'h0000;
        {upper_byte_mask, lower_byte_mask} = 2'h0;
    end

    // Drives one command for one clock, never two closer than a clock.
    task automatic op(input logic [2:0] rcw, input logic [11:0] a,
                      input logic [15:0] d, input logic [1:0] m);
        @(posedge clk);
        {cs_n, ras_n, cas_n, we_n} <= {1'b0, rcw};
        addr <= a;
        dq_in <= d;
        {upper_byte_mask, lower_byte_mask} <= m;
    endtask : op

    // Deselects the device; waits made of these keep bank timing.
    task automatic idle(input logic [1:0] m);
        @(posedge clk);
        cs_n <= 1'b1;
        addr <= ~addr;
        dq_in <= ~dq_in;
        {upper_byte_mask, lower_byte_mask} <= m;
    endtask : idle
endmodule : sdbc_ctl_model

// file: tb_sdram_burst_precharge_core.sv
// Purpose: Self-checking bench for the SDRAM core over commands and AHB-Lite.
// Assumes: Zero wait state slave, column latency three, burst length four.
// Notes:   Outputs are sampled at the falling edge before the using edge.

`timescale 1ns/1ps

module tb_sdram_burst_precharge_core;
    logic        clk, rstn, cs_n, ras_n, cas_n, we_n, upper_byte_mask, lower_byte_mask;
    logic [11:0] addr;
    logic [15:0] dq_in, dq_out;
    logic [1:0]  dq_oe_n, htrans;
    logic        hsel, hwrite, hready, hreadyout, hresp;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          n_fail, n_checks, k;
    logic [1:0]  oe_exp [8] = '{2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3};
    logic [15:0] rd_exp [3] = '{16'hb0a1, 16'hb0b0, 16'hb0b1};

    assign hready = hreadyout;

    sdbc_core sdbc_core_i (.clk(clk), .rstn(rstn), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .addr(addr), .upper_byte_mask(upper_byte_mask),
        .lower_byte_mask(lower_byte_mask), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp));
    sdbc_ctl_model sdbc_ctl_model_i (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .addr(addr), .upper_byte_mask(upper_byte_mask),
        .lower_byte_mask(lower_byte_mask), .dq_in(dq_in));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_ready();
        int i;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (hreadyout !== 1'b1 && i < 16);
        if (i >= 16)
        begin
            n_fail++;
            final_report();
        end
    endtask : wait_ready

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        hsel <= 1'b0;
        chk(hresp, 1'b0);
    endtask : ahb

    // ************************************************************
    // Stimulus
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #500000;
        n_fail++;
        final_report();
    end

    initial
    begin
        {rstn, hsel, hwrite, htrans, haddr, hwdata, n_fail, n_checks} = '0;
        hsize = 3'h2;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk(dq_oe_n, 2'h3);
        ahb(1'b0, sdbc_pkg::CFG_OFS, 32'h0000_0000);
        chk(rd, 32'(sdbc_pkg::CFG_RST));
        ahb(1'b1, 32'h0000_0008, 32'hffff_ffff);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("Test registers done");
        sdbc_ctl_model_i.op(3'h3, 12'h025, 16'h0000, 2'h0);
        repeat (3) sdbc_ctl_model_i.idle(2'h0);
        sdbc_ctl_model_i.op(3'h4, 12'h004, 16'ha0a0, 2'h0);
        sdbc_ctl_model_i.op(3'h7, 12'h000, 16'ha0a1, 2'h0);
        for (k = 0; k < 4; k++)
            sdbc_ctl_model_i.op(k == 0 ? 3'h4 : 3'h7, 12'h306, 16'hb0b0 + 16'(k),
                                {1'b0, k == 3});
        repeat (2) sdbc_ctl_model_i.idle(2'h0);
        sdbc_ctl_model_i.op(3'h5, 12'h705, 16'h5a5a, 2'h0);
        for (k = 0; k < 8; k++)
        begin
            @(negedge clk);
            chk(dq_oe_n, oe_exp[k]);
            if (k >= 3 && k <= 5)
                chk(dq_out, rd_exp[k - 3]);
            if (k == 6)
                chk(dq_out[7:0], 8'hb2);
            sdbc_ctl_model_i.idle({k == 3, 1'b0});
        end
        repeat (4) sdbc_ctl_model_i.idle(2'h0);
        ahb(1'b0, sdbc_pkg::STAT_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("Test burst write and read done");
        sdbc_ctl_model_i.op(3'h5, 12'h800, 16'h0000, 2'h0);
        for (k = 0; k < 6; k++)
        begin
            @(negedge clk);
            chk(dq_oe_n, 2'h3);
            sdbc_ctl_model_i.idle(2'h0);
        end
        sdbc_ctl_model_i.op(3'h3, 12'h000, 16'h0000, 2'h0);
        sdbc_ctl_model_i.op(3'h3, 12'h801, 16'h0000, 2'h0);
        repeat (5) sdbc_ctl_model_i.idle(2'h0);
        ahb(1'b0, sdbc_pkg::STAT_OFS, 32'h0000_0000);
        chk(rd[1:0], 2'h3);
        sdbc_ctl_model_i.op(3'h2, 12'h800, 16'h0000, 2'h0);
        repeat (4) sdbc_ctl_model_i.idle(2'h0);
        ahb(1'b0, sdbc_pkg::STAT_OFS, 32'h0000_0000);
        chk(rd[3:0], 4'h1);
        sdbc_ctl_model_i.op(3'h3, 12'h801, 16'h0000, 2'h0);
        repeat (5) sdbc_ctl_model_i.idle(2'h0);
        sdbc_ctl_model_i.op(3'h2, 12'hc00, 16'h0000, 2'h0);
        repeat (4) sdbc_ctl_model_i.idle(2'h0);
        ahb(1'b0, sdbc_pkg::STAT_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("Test bank precharge done");
        ahb(1'b1, sdbc_pkg::CFG_OFS, 32'(sdbc_pkg::BL_FULL));
        ahb(1'b0, sdbc_pkg::CFG_OFS, 32'h0000_0000);
        chk(rd, 32'(sdbc_pkg::BL_FULL));
        sdbc_ctl_model_i.op(3'h3, 12'h025, 16'h0000, 2'h0);
        sdbc_ctl_model_i.op(3'h4, 12'h400, 16'h1234, 2'h0);
        repeat (5) sdbc_ctl_model_i.idle(2'h0);
        ahb(1'b0, sdbc_pkg::STAT_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0021);
        sdbc_ctl_model_i.op(3'h5, 12'h000, 16'h0000, 2'h0);
        sdbc_ctl_model_i.op(3'h6, 12'h000, 16'h0000, 2'h0);
        repeat (2) sdbc_ctl_model_i.idle(2'h0);
        @(negedge clk);
        chk({dq_oe_n, dq_out}, 18'h0_1234);
        sdbc_ctl_model_i.idle(2'h0);
        @(negedge clk);
        chk(dq_oe_n, 2'h3);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        ahb(1'b0, sdbc_pkg::CFG_OFS, 32'h0000_0000);
        chk(rd, 32'(sdbc_pkg::CFG_RST));
        $display("Test full page and reset done");
        final_report();
    end
endmodule : tb_sdram_burst_precharge_core
